/* verilog/vsfr_map.svh */
// Purpose: constants for the valley-skip frequency reduction block
// Assumes: 100 MHz core clock
// Notes:   times are kept in their own unit, cycles are derived
`ifndef VSFR_MAP_SVH
`define VSFR_MAP_SVH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define VSFR_CLK_KHZ 100000

// ----------------------------------------------------------------------
// times
// ----------------------------------------------------------------------
`define VSFR_EVAL_MS 48
`define VSFR_SOFT_MS 12
`define VSFR_SOFT_STEPS 4
`define VSFR_RING_LONG_US 5
`define VSFR_RING_SHORT_US 2
`define VSFR_MAX_OFF_US 50
`define VSFR_OVP_BLANK_US 1

// ----------------------------------------------------------------------
// derived cycle counts (all divide exactly, all above one cycle)
// ----------------------------------------------------------------------
`define VSFR_EVAL_CYC (`VSFR_EVAL_MS * `VSFR_CLK_KHZ)
`define VSFR_SOFT_STEP_CYC ((`VSFR_SOFT_MS * `VSFR_CLK_KHZ) / `VSFR_SOFT_STEPS)
`define VSFR_RING_LONG_CYC ((`VSFR_RING_LONG_US * `VSFR_CLK_KHZ) / 1000)
`define VSFR_RING_SHORT_CYC ((`VSFR_RING_SHORT_US * `VSFR_CLK_KHZ) / 1000)
`define VSFR_MAX_OFF_CYC ((`VSFR_MAX_OFF_US * `VSFR_CLK_KHZ) / 1000)
`define VSFR_OVP_BLANK_CYC ((`VSFR_OVP_BLANK_US * `VSFR_CLK_KHZ) / 1000)

// ----------------------------------------------------------------------
// counter limits and reset values
// ----------------------------------------------------------------------
`define VSFR_VS_MIN 3'h1
`define VSFR_VS_MAX 3'h7
`define VSFR_VS_RESET 3'h1
`define VSFR_ZC_MAX 3'h7
`define VSFR_STEP_LAST 2'h3

`endif

/* verilog/vsfr_pkg.sv */
// Purpose: types for the valley-skip frequency reduction block
// Assumes: nothing beyond the constants header
// Notes:   holds types only
package vsfr_pkg;

  // ----------------------------------------------------------------------
  // operating phase
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    VSFR_PRECHARGE,
    VSFR_ACTIVE,
    VSFR_LATCHED
  } vsfr_state_t;

endpackage : vsfr_pkg

/* verilog/vsfr_sync.sv */
// Purpose: two-flop synchroniser for comparator levels
// Assumes: levels are slow against the clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps

module vsfr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      dout <= '0;
    end else if (clkEn) begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule : vsfr_sync

/* verilog/vsfr_top.sv */
// Purpose: digital switch-on control of a quasi-resonant flyback controller
// Assumes: comparator outputs arrive as levels; analog off path gives offRequest
// Notes:   long timers are parameters so a simulation can shorten them
//
// Operation
// - supply above turn-on: cell off, start
// - soft-start: 12ms, four equal limit steps
// - on from digital path, off from analog
// - valley counter holds crossings to skip
// - feedback evaluated against thresholds every 48ms
// - always below lower hold: increment, max 7
// - between lower and upper hold: keep value
// - above upper hold at any time in the period: decrement, min 1
// - above fast reset: force counter to 1
// - valley counter always within 1 to 7
// - valley counter starts at 1
// - hold thresholds follow detected line level
// - crossing counter stays within 0 to 7
// - each falling crossing while off counts one
// - crossing counter cleared when gate rises
// - valley overvoltage while off: latch after blanking
// - after ringing time, on when crossings reach count
// - gate held low during ringing suppression
// - max off-time forces gate on
`timescale 1ns/1ps
`include "vsfr_map.svh"

module vsfr_top #(
  parameter int unsigned EVAL_CYC = `VSFR_EVAL_CYC,
  parameter int unsigned SOFT_STEP_CYC = `VSFR_SOFT_STEP_CYC,
  parameter int unsigned RING_LONG_CYC = `VSFR_RING_LONG_CYC,
  parameter int unsigned RING_SHORT_CYC = `VSFR_RING_SHORT_CYC,
  parameter int unsigned MAX_OFF_CYC = `VSFR_MAX_OFF_CYC,
  parameter int unsigned OVP_BLANK_CYC = `VSFR_OVP_BLANK_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic supplyAboveOn,
  input wire logic fbAboveLower,
  input wire logic fbAboveUpper,
  input wire logic fbAboveFastReset,
  input wire logic zcAboveZero,
  input wire logic zcAboveOvp,
  input wire logic zcAboveRing,
  input wire logic lineHigh,
  input wire logic offRequest,
  output logic startupCellOn,
  output logic gateDrive,
  output logic [1:0] softStep,
  output logic softStartDone,
  output logic [2:0] valleySkipCount,
  output logic [2:0] zeroCrossCount,
  output logic holdThresholdHighLine,
  output logic latchedOff
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [2:0] satInc(input logic [2:0] val, input logic [2:0] top);
    satInc = (val >= top) ? top : val + 3'h1;
  endfunction : satInc
  function automatic logic [2:0] satDec(input logic [2:0] val, input logic [2:0] bottom);
    satDec = (val <= bottom) ? bottom : val - 3'h1;
  endfunction : satDec

  // ----------------------------------------------------------------------
  // synchronised comparator levels
  // ----------------------------------------------------------------------
  logic [8:0] syncIn, syncOut;
  logic supplyOnS, fbLowerS, fbUpperS, fbFastS, zcZeroS, zcOvpS, zcRingS, lineS;
  logic offReqS;

  assign syncIn = {supplyAboveOn, fbAboveLower, fbAboveUpper, fbAboveFastReset,
                   zcAboveZero, zcAboveOvp, zcAboveRing, lineHigh, offRequest};
  assign {supplyOnS, fbLowerS, fbUpperS, fbFastS, zcZeroS, zcOvpS, zcRingS, lineS,
          offReqS} = syncOut;

  vsfr_sync #(.WIDTH(9)) uSync (
    .clk(clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .din(syncIn),
    .dout(syncOut)
  );

  // ----------------------------------------------------------------------
  // phase control
  // ----------------------------------------------------------------------
  vsfr_pkg::vsfr_state_t state;
  logic [31:0] ovpCnt;
  logic ovpTrip;

  // blanking filters short overshoots after turn-off
  assign ovpTrip = (state == vsfr_pkg::VSFR_ACTIVE) && !gateDrive && zcOvpS &&
                   (ovpCnt >= OVP_BLANK_CYC - 1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= vsfr_pkg::VSFR_PRECHARGE;
    end else if (clkEn) begin
      case (state)
        vsfr_pkg::VSFR_PRECHARGE: begin
          if (supplyOnS) begin
            state <= vsfr_pkg::VSFR_ACTIVE;
          end
        end
        vsfr_pkg::VSFR_ACTIVE: begin
          if (ovpTrip) begin
            state <= vsfr_pkg::VSFR_LATCHED;
          end
        end
        vsfr_pkg::VSFR_LATCHED: state <= vsfr_pkg::VSFR_LATCHED;
        default: state <= vsfr_pkg::VSFR_PRECHARGE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovpCnt <= '0;
    end else if (clkEn) begin
      if (state == vsfr_pkg::VSFR_ACTIVE && !gateDrive && zcOvpS) begin
        ovpCnt <= (ovpCnt >= OVP_BLANK_CYC) ? ovpCnt : ovpCnt + 32'h1;
      end else begin
        ovpCnt <= '0;
      end
    end
  end

  assign startupCellOn = (state == vsfr_pkg::VSFR_PRECHARGE);
  assign latchedOff = (state == vsfr_pkg::VSFR_LATCHED);

  // ----------------------------------------------------------------------
  // soft-start
  // ----------------------------------------------------------------------
  logic [31:0] softCnt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      softCnt <= '0;
      softStep <= '0;
      softStartDone <= 1'b0;
    end else if (clkEn && state == vsfr_pkg::VSFR_ACTIVE && !softStartDone) begin
      if (softCnt >= SOFT_STEP_CYC - 1) begin
        softCnt <= '0;
        if (softStep == `VSFR_STEP_LAST) begin
          softStartDone <= 1'b1;
        end else begin
          softStep <= softStep + 2'h1;
        end
      end else begin
        softCnt <= softCnt + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // switch-on determination
  // ----------------------------------------------------------------------
  logic [31:0] offCnt, ringCyc;
  logic ringDone, turnOn, next_gateDrive;

  // ringing voltage above the level allows the shorter suppression
  assign ringCyc = zcRingS ? RING_SHORT_CYC : RING_LONG_CYC;
  assign ringDone = (offCnt >= ringCyc);
  assign turnOn = (state == vsfr_pkg::VSFR_ACTIVE) && !gateDrive && !ovpTrip &&
                  ((ringDone && zeroCrossCount >= valleySkipCount) ||
                   offCnt >= MAX_OFF_CYC);

  always_comb begin
    next_gateDrive = gateDrive;
    if (state != vsfr_pkg::VSFR_ACTIVE || ovpTrip) begin
      next_gateDrive = 1'b0;
    end else if (gateDrive && offReqS) begin
      next_gateDrive = 1'b0;
    end else if (turnOn) begin
      next_gateDrive = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gateDrive <= 1'b0;
    end else if (clkEn) begin
      gateDrive <= next_gateDrive;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      offCnt <= '0;
    end else if (clkEn) begin
      if (gateDrive || state != vsfr_pkg::VSFR_ACTIVE) begin
        offCnt <= '0;
      end else if (offCnt < MAX_OFF_CYC) begin
        offCnt <= offCnt + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // zero-crossing counter
  // ----------------------------------------------------------------------
  logic zcPrev, zcFall;

  assign zcFall = zcPrev && !zcZeroS && !gateDrive;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      zcPrev <= 1'b0;
      zeroCrossCount <= '0;
    end else if (clkEn) begin
      zcPrev <= zcZeroS;
      if (next_gateDrive && !gateDrive) begin
        zeroCrossCount <= '0;
      end else if (zcFall) begin
        zeroCrossCount <= satInc(zeroCrossCount, `VSFR_ZC_MAX);
      end
    end
  end

  // ----------------------------------------------------------------------
  // valley-skip counter
  // ----------------------------------------------------------------------
  logic [31:0] evalCnt;
  logic evalEnd, seenLower, seenUpper, anyLower, anyUpper;

  assign evalEnd = (state == vsfr_pkg::VSFR_ACTIVE) && (evalCnt >= EVAL_CYC - 1);
  assign anyLower = seenLower || fbLowerS;
  assign anyUpper = seenUpper || fbUpperS;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evalCnt <= '0;
    end else if (clkEn) begin
      evalCnt <= (state != vsfr_pkg::VSFR_ACTIVE || evalEnd) ? 32'h0 : evalCnt + 32'h1;
    end
  end

  // a crossing in the boundary cycle opens the next period, never lost
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seenLower <= 1'b0;
      seenUpper <= 1'b0;
    end else if (clkEn) begin
      if (evalEnd) begin
        seenLower <= fbLowerS;
        seenUpper <= fbUpperS;
      end else begin
        seenLower <= anyLower;
        seenUpper <= anyUpper;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      valleySkipCount <= `VSFR_VS_RESET;
    end else if (clkEn) begin
      if (state != vsfr_pkg::VSFR_ACTIVE) begin
        valleySkipCount <= `VSFR_VS_RESET;
      end else if (fbFastS) begin
        valleySkipCount <= `VSFR_VS_MIN;
      end else if (evalEnd) begin
        if (!anyLower) begin
          valleySkipCount <= satInc(valleySkipCount, `VSFR_VS_MAX);
        end else if (anyUpper) begin
          valleySkipCount <= satDec(valleySkipCount, `VSFR_VS_MIN);
        end
      end
      // otherwise held, the crossing is the skip target
    end
  end

  // ----------------------------------------------------------------------
  // line-dependent hold threshold select
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      holdThresholdHighLine <= 1'b0;
    end else if (clkEn) begin
      holdThresholdHighLine <= lineS;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_CELL_OFF_ACTIVE: assert property (
    @(posedge clk) disable iff (!arst_n)
    clkEn && state == vsfr_pkg::VSFR_PRECHARGE && supplyOnS |=> !startupCellOn)
    else $error("startup cell on after start");
  AST_VS_RANGE: assert property (
    @(posedge clk) disable iff (!arst_n)
    valleySkipCount >= `VSFR_VS_MIN && valleySkipCount <= `VSFR_VS_MAX)
    else $error("valley count out of range");
  AST_FAST_RESET: assert property (
    @(posedge clk) disable iff (!arst_n)
    clkEn && fbFastS && state == vsfr_pkg::VSFR_ACTIVE |=> valleySkipCount == 3'h1)
    else $error("fast reset did not force one");
  AST_VS_UP: assert property (
    @(posedge clk) disable iff (!arst_n)
    clkEn && evalEnd && !fbFastS && !anyLower |=>
      valleySkipCount == satInc($past(valleySkipCount), 3'h7))
    else $error("valley count did not rise");
  AST_VS_DOWN: assert property (
    @(posedge clk) disable iff (!arst_n)
    clkEn && evalEnd && !fbFastS && anyLower && anyUpper |=>
      valleySkipCount == satDec($past(valleySkipCount), 3'h1))
    else $error("valley count did not fall");
  AST_ZC_CLEAR: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(gateDrive) |-> zeroCrossCount == 3'h0)
    else $error("crossing count not cleared at turn-on");
  AST_ZC_STEP: assert property (
    @(posedge clk) disable iff (!arst_n)
    clkEn && zcFall && !turnOn && zeroCrossCount < 3'h7 |=>
      zeroCrossCount == $past(zeroCrossCount) + 3'h1)
    else $error("crossing not counted");
  AST_RING_HOLD: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(gateDrive) |-> $past(offCnt) >= $past(ringCyc))
    else $error("gate on inside ringing suppression");
  AST_MAX_OFF: assert property (
    @(posedge clk) disable iff (!arst_n)
    clkEn && state == vsfr_pkg::VSFR_ACTIVE && !gateDrive && !ovpTrip &&
      offCnt >= MAX_OFF_CYC |=> gateDrive)
    else $error("max off-time did not turn gate on");
  AST_LATCH_HOLD: assert property (
    @(posedge clk) disable iff (!arst_n)
    latchedOff |=> latchedOff && !gateDrive)
    else $error("latch released or gate on");

endmodule : vsfr_top

/* verification/vsfr_top_test.sv */
// Purpose: self-checking bench for the valley-skip switch-on control
// Assumes: shortened timers; the bench plays the comparators and the analog off path
// Notes:   valley and soft-start changes are checked against queued notes
`timescale 1ns/1ps

module vsfr_top_test;
  // ----------------------------------------------------------------------
  // setup
  // ----------------------------------------------------------------------
  localparam int P_EVAL = 200;
  localparam int P_SOFT = 50;
  localparam int P_RLONG = 10;
  localparam int P_RSHORT = 4;
  localparam int P_MAXOFF = 60;
  localparam int P_BLANK = 5;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic supplyAboveOn = 1'b0;
  logic fbAboveLower = 1'b0;
  logic fbAboveUpper = 1'b0;
  logic fbAboveFastReset = 1'b0;
  logic zcAboveZero = 1'b0;
  logic zcAboveOvp = 1'b0;
  logic zcAboveRing = 1'b0;
  logic lineHigh = 1'b0;
  logic offRequest = 1'b0;
  logic clkEn = 1'b1;
  logic startupCellOn, gateDrive, softStartDone, holdThresholdHighLine, latchedOff;
  logic [1:0] softStep;
  logic [2:0] valleySkipCount, zeroCrossCount;
  logic [31:0] rs = 32'h00003CDA;
  logic [2:0] qVs[$];
  int qGap[$];
  logic [2:0] qSs[$];
  logic [2:0] pVs, pZc;
  logic [1:0] pSs;
  logic pGate;
  bit zcOn, seenFall;
  int cyc, cE, n, offLen, phase, lastVsT, lastSsT, mismatches, compares;

  vsfr_top #(.EVAL_CYC(P_EVAL), .SOFT_STEP_CYC(P_SOFT), .RING_LONG_CYC(P_RLONG),
    .RING_SHORT_CYC(P_RSHORT), .MAX_OFF_CYC(P_MAXOFF), .OVP_BLANK_CYC(P_BLANK)) u_vsfr_top (
    .clk(clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .supplyAboveOn(supplyAboveOn),
    .fbAboveLower(fbAboveLower),
    .fbAboveUpper(fbAboveUpper),
    .fbAboveFastReset(fbAboveFastReset),
    .zcAboveZero(zcAboveZero),
    .zcAboveOvp(zcAboveOvp),
    .zcAboveRing(zcAboveRing),
    .lineHigh(lineHigh),
    .offRequest(offRequest),
    .startupCellOn(startupCellOn),
    .gateDrive(gateDrive),
    .softStep(softStep),
    .softStartDone(softStartDone),
    .valleySkipCount(valleySkipCount),
    .zeroCrossCount(zeroCrossCount),
    .holdThresholdHighLine(holdThresholdHighLine),
    .latchedOff(latchedOff)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic tmo(input int got, input int lim);
    if (got >= lim) begin
      mismatches++;
      $display("MISMATCH %0t wait ran out", $time);
      summarize();
    end
  endtask : tmo

  task automatic cmpCount(input logic [2:0] got, input logic [2:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t count got %0h exp %0h", $time, got, exp);
    end
  endtask : cmpCount

  task automatic cmpFlag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : cmpFlag

  task automatic cmpTime(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("MISMATCH %0t span %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : cmpTime

  task automatic step();
    @(posedge clk);
    #1;
    n++;
  endtask : step

  // mid-period moves only, so a period sees at most two levels
  task automatic waitRel(input int t);
    repeat (t - (cyc - cE)) @(posedge clk);
    #2;
  endtask : waitRel

  task automatic setFb(input logic lo, input logic up, input logic fr);
    fbAboveLower = lo;
    fbAboveUpper = up;
    fbAboveFastReset = fr;
  endtask : setFb

  task automatic waitFall();
    n = 0;
    while (gateDrive !== 1'b1 && n < 100) step();
    while (gateDrive !== 1'b0 && n < 100) step();
    tmo(n, 100);
  endtask : waitFall

  task automatic checkReset();
    cmpFlag(startupCellOn, 1'b1);
    cmpFlag(gateDrive, 1'b0);
    cmpFlag(latchedOff, 1'b0);
    cmpCount(valleySkipCount, 3'h1);
    cmpCount(zeroCrossCount, 3'h0);
    cmpCount({1'b0, softStep}, 3'h0);
    cmpFlag(softStartDone, 1'b0);
  endtask : checkReset

  // ----------------------------------------------------------------------
  // far side: off path ends each on-time, ringing gives crossings
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    #2;
    offRequest = gateDrive;
    if (gateDrive !== 1'b0) begin
      phase = 0;
      zcAboveZero = 1'b0;
      void'(rnd());
      zcAboveRing = rs[0];
    end else begin
      phase = (phase == 5) ? 0 : phase + 1;
      zcAboveZero = zcOn && phase >= 1 && phase <= 3;
    end
  end

  // ----------------------------------------------------------------------
  // watcher
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    #1;
    if (arst_n === 1'b1) begin
      if (valleySkipCount !== pVs) begin
        if (qVs.size() == 0) begin
          cmpCount(valleySkipCount, pVs);
        end else begin
          cmpCount(valleySkipCount, qVs[0]);
          if (qGap[0] > 0) cmpTime(cyc - lastVsT, qGap[0] * P_EVAL, qGap[0] * P_EVAL);
          void'(qVs.pop_front());
          void'(qGap.pop_front());
        end
        lastVsT = cyc;
      end
      if (softStep !== pSs) begin
        cmpCount({1'b0, softStep}, qSs.size() > 0 ? qSs.pop_front() : 3'h0);
        if (softStep > 2'h1) cmpTime(cyc - lastSsT, P_SOFT, P_SOFT);
        lastSsT = cyc;
      end
      if (gateDrive === 1'b1 && pGate === 1'b0) begin
        if (seenFall) begin
          cmpTime(offLen, (zcAboveRing ? P_RSHORT : P_RLONG) + 1, P_MAXOFF + 1);
          cmpFlag(pZc >= pVs || offLen >= P_MAXOFF + 1, 1'b1);
        end
        cmpCount(zeroCrossCount, 3'h0);
      end else if (zeroCrossCount !== pZc) begin
        cmpCount(zeroCrossCount, pZc + 3'h1);
        cmpFlag(gateDrive, 1'b0);
      end
      if (gateDrive === 1'b0 && pGate === 1'b1) seenFall = 1'b1;
      offLen = (gateDrive === 1'b0) ? offLen + 1 : 0;
    end else begin
      offLen = 0;
      seenFall = 1'b0;
    end
    pVs = valleySkipCount;
    pZc = zeroCrossCount;
    pSs = softStep;
    pGate = gateDrive;
  end

  // line level takes a random value every 94 cycles
  initial begin
    repeat (20) @(posedge clk);
    repeat (40) begin
      #2;
      void'(rnd());
      lineHigh = rs[1];
      repeat (4) @(posedge clk);
      #1;
      cmpFlag(holdThresholdHighLine, lineHigh);
      repeat (90) @(posedge clk);
    end
  end

  initial begin
    repeat (12000) @(posedge clk);
    tmo(1, 1);
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    qVs = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1,
      3'h2, 3'h3, 3'h1, 3'h2};
    qGap = '{0, 1, 1, 1, 1, 1, 5, 1, 1, 1, 1, 1, 3, 1, 0, 0};
    qSs = '{3'h1, 3'h2, 3'h3};
    zcOn = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    checkReset();
    arst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    checkReset();
    #1;
    supplyAboveOn = 1'b1;
    n = 0;
    while (startupCellOn !== 1'b0 && n < 10) step();
    tmo(n, 10);
    cmpTime(n, 3, 3);
    cE = cyc;
    n = 0;
    while (softStartDone !== 1'b1 && n < 400) step();
    tmo(n, 400);
    cmpTime(n, 4 * P_SOFT - 1, 4 * P_SOFT + 1);
    #1;
    supplyAboveOn = 1'b0;
    // no crossings while counts hold, so max off-time ends every gap
    waitRel(P_EVAL * 17 / 2);
    setFb(1'b1, 1'b0, 1'b0);
    zcOn = 1'b0;
    waitRel(P_EVAL * 21 / 2);
    setFb(1'b1, 1'b1, 1'b0);
    zcOn = 1'b1;
    waitRel(P_EVAL * 35 / 2);
    setFb(1'b0, 1'b0, 1'b0);
    waitRel(P_EVAL * 41 / 2);
    setFb(1'b1, 1'b1, 1'b1);
    repeat (6) @(posedge clk);
    #1;
    cmpCount(valleySkipCount, 3'h1);
    #1;
    setFb(1'b0, 1'b0, 1'b0);
    waitRel(P_EVAL * 45 / 2);
    cmpTime(qVs.size(), 0, 0);
    cmpTime(qSs.size(), 0, 0);
    cmpFlag(startupCellOn, 1'b0);
    zcOn = 1'b0;
    // hold level keeps the count still while the overvoltage part runs
    setFb(1'b1, 1'b0, 1'b0);
    // a spike shorter than the blanking must not latch
    waitFall();
    #1;
    zcAboveOvp = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    zcAboveOvp = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    cmpFlag(latchedOff, 1'b0);
    waitFall();
    #1;
    // leaving operation puts the valley count back to one
    qVs.push_back(3'h1);
    qGap.push_back(0);
    zcAboveOvp = 1'b1;
    n = 0;
    while (latchedOff !== 1'b1 && n < 20) step();
    tmo(n, 20);
    cmpTime(n, P_BLANK, P_BLANK + 4);
    #1;
    zcAboveOvp = 1'b0;
    n = 0;
    repeat (P_MAXOFF * 2) begin
      @(posedge clk);
      #1;
      if (gateDrive !== 1'b0 || latchedOff !== 1'b1) n++;
    end
    cmpTime(n, 0, 0);
    cmpTime(qVs.size(), 0, 0);
    #1;
    arst_n = 1'b0;
    #1;
    checkReset();
    repeat (2) @(posedge clk);
    #2;
    arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    checkReset();
    // frozen clock enable holds the start-up path still
    #1;
    clkEn = 1'b0;
    supplyAboveOn = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    cmpFlag(startupCellOn, 1'b1);
    #1;
    clkEn = 1'b1;
    n = 0;
    while (startupCellOn !== 1'b0 && n < 10) step();
    tmo(n, 10);
    cmpTime(n, 3, 3);
    summarize();
  end
endmodule : vsfr_top_test
